// *** design/dma_regs_pkg.sv ***
// Package: register map, field positions and timing constants of the DMA register block
`default_nettype none
package dma_regs_pkg;
   localparam int          NUM_CH         = 2;
   localparam logic [15:0] H2C_BASE_0     = 16'h0000;
   localparam logic [15:0] H2C_BASE_1     = 16'h0100;
   localparam logic [15:0] C2H_BASE_0     = 16'h2000;
   localparam logic [15:0] C2H_BASE_1     = 16'h2100;
   localparam logic [15:0] COMMON_BASE    = 16'h4000;
   localparam logic [7:0]  OFS_CONTROL    = 8'h04;
   localparam logic [7:0]  OFS_NEXT_PTR   = 8'h08;
   localparam logic [7:0]  OFS_HOST_PTR   = 8'h0c;
   localparam logic [7:0]  OFS_BYTE_COUNT = 8'h1c;
   // Engine control fields
   localparam int CTL_IRQ_EN     = 0;
   localparam int CTL_IRQ_ACT    = 1;
   localparam int CTL_DESC_DONE  = 2;
   localparam int CTL_ALIGN_ERR  = 3;
   localparam int CTL_FETCH_ERR  = 4;
   localparam int CTL_ABORT      = 5;
   localparam int CTL_ENABLE     = 8;
   localparam int CTL_ACTIVE     = 10;
   localparam int CTL_STARVED    = 11;
   localparam int CTL_RST_REQ    = 14;
   localparam int CTL_ENG_RST    = 15;
   // Common register fields
   localparam int CMN_GIE        = 0;
   localparam int CMN_IRQ_ACT    = 1;
   localparam int CMN_IRQ_PEND   = 2;
   localparam int CMN_IRQ_MODE   = 3;
   localparam int CMN_USR_EN     = 4;
   localparam int CMN_USR_ACT    = 5;
   localparam int CMN_H2C_LSB    = 16;
   localparam int CMN_C2H_LSB    = 24;
   localparam int PTR_LSB        = 5;
   localparam int CNT_LSB        = 2;
   // One-second sample interval at 250 MHz
   localparam longint SAMPLE_PERIOD_NS = 64'd1000000000;
   localparam longint CLK_PERIOD_NS    = 64'd4;
   localparam int     SAMPLE_CYCLES    = int'(SAMPLE_PERIOD_NS / CLK_PERIOD_NS);

   // Register access from the host, one word per strobe
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [31:0] wdata;
   } reg_req_type;

   // Events reported by the engine datapath
   typedef struct packed {
      logic        irq_event;
      logic        desc_done;
      logic        align_err;
      logic        fetch_err;
      logic        sw_abort;
      logic        active;
      logic [15:0] bytes;
   } eng_event_type;
endpackage
`default_nettype wire

// *** design/dma_rate_counter.sv ***
// Per-second completed byte counter with two-bit sample count
`default_nettype none
module dma_rate_counter
   import dma_regs_pkg::*;
#(
   parameter int SAMPLE_LEN = SAMPLE_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic [15:0] bytes,
   output logic [31:0]      count_word
);
   typedef struct packed {
      logic [31:0] timer;
      logic [31:0] accum;
      logic [29:0] held;
      logic [1:0]  samples;
   } rate_state_type;
   rate_state_type s_q, s_d;

   // Accumulate bytes, latch the total every second
   always_comb begin
      s_d = s_q;
      s_d.accum = s_q.accum + {16'h0000, bytes};
      if (s_q.timer == 32'(SAMPLE_LEN - 1)) begin
         s_d.timer   = 32'h0;
         s_d.held    = s_q.accum[31:CNT_LSB];
         s_d.samples = s_q.samples + 2'h1;
         s_d.accum   = {16'h0000, bytes};
      end else begin
         s_d.timer = s_q.timer + 32'h1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign count_word = {s_q.held, s_q.samples};
endmodule // dma_rate_counter
`default_nettype wire

// *** design/dma_engine_ctl.sv ***
// Control, status and pointer registers of one DMA engine
`default_nettype none
module dma_engine_ctl
   import dma_regs_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          resetn,
   input  wire logic          sel,
   input  wire logic          wr,
   input  wire logic [7:0]    ofs,
   input  wire logic [31:0]   wdata,
   input  wire eng_event_type ev,
   input  wire logic          user_ack,
   output logic [31:0]        control_word,
   output logic [31:0]        next_ptr_word,
   output logic [31:0]        host_ptr_word,
   output logic               irq,
   output logic               fetch_start,
   output logic               reset_request,
   output logic               engine_reset
);
   typedef struct packed {
      logic [5:0]  flags;      // Bits 5..0
      logic        enable;
      logic        starved;
      logic        rst_req;
      logic        eng_rst;
      logic [26:0] next_ptr;
      logic [26:0] host_ptr;
   } eng_state_type;
   eng_state_type s_q, s_d;
   logic w_ctl;

   assign w_ctl = sel && wr && (ofs == OFS_CONTROL);

   // Flag update: hardware set wins over write-one-to-clear
   always_comb begin
      s_d = s_q;
      if (w_ctl) begin
         s_d.flags[CTL_IRQ_EN] = wdata[CTL_IRQ_EN];
         for (int i = CTL_IRQ_ACT; i <= CTL_ABORT; i++) begin
            if (wdata[i]) s_d.flags[i] = 1'b0;
         end
         s_d.enable  = wdata[CTL_ENABLE];
         s_d.rst_req = s_q.rst_req | wdata[CTL_RST_REQ];
         s_d.eng_rst = wdata[CTL_ENG_RST];
      end else begin
         s_d.eng_rst = 1'b0;
      end
      if (ev.irq_event) s_d.flags[CTL_IRQ_ACT]   = 1'b1;
      if (ev.desc_done) s_d.flags[CTL_DESC_DONE] = 1'b1;
      if (ev.align_err) s_d.flags[CTL_ALIGN_ERR] = 1'b1;
      if (ev.fetch_err) s_d.flags[CTL_FETCH_ERR] = 1'b1;
      if (ev.sw_abort)  s_d.flags[CTL_ABORT]     = 1'b1;
      if (user_ack) s_d.rst_req = 1'b0;
      if (sel && wr && ofs == OFS_NEXT_PTR && !s_q.enable) begin
         s_d.next_ptr = wdata[31:PTR_LSB];
      end
      if (sel && wr && ofs == OFS_HOST_PTR) begin
         s_d.host_ptr = wdata[31:PTR_LSB];
      end
      // Waiting when enabled with nothing handed over
      s_d.starved = s_q.enable && !ev.active && (s_q.next_ptr == s_q.host_ptr);
      if (s_q.eng_rst) begin
         s_d = '0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign control_word  = {16'h0000, s_q.eng_rst, s_q.rst_req, 2'b00, s_q.starved,
                           ev.active, 1'b0, s_q.enable, 2'b00, s_q.flags};
   assign next_ptr_word = {s_q.next_ptr, 5'b00000};
   assign host_ptr_word = {s_q.host_ptr, 5'b00000};
   assign irq           = s_q.flags[CTL_IRQ_EN] & s_q.flags[CTL_IRQ_ACT];
   assign fetch_start   = s_q.enable && (s_q.next_ptr != s_q.host_ptr);
   assign reset_request = s_q.rst_req;
   assign engine_reset  = s_q.eng_rst;
endmodule // dma_engine_ctl
`default_nettype wire

// *** design/dma_regs_top.sv ***
// Register block of a scatter-gather packet DMA with host_to_card and card_to_host engines
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module dma_regs_top
   import dma_regs_pkg::*;
#(
   parameter int          SAMPLE_LEN  = SAMPLE_CYCLES,
   parameter logic        LEGACY_IRQ  = 1'b0
) (
   input  wire logic                   clk,
   input  wire logic                   resetn,
   input  wire reg_req_type            req,
   input  wire eng_event_type [3:0]    events,
   input  wire logic [3:0]             user_ack,
   input  wire logic                   user_irq_event,
   output logic [31:0]                 rdata,
   output logic                        rvalid,
   output logic                        dma_irq,
   output logic                        user_irq,
   output logic [3:0]                  fetch_start,
   output logic [3:0]                  reset_request,
   output logic [3:0]                  user_reset
);
   typedef struct packed {
      logic        gie;
      logic        usr_en;
      logic        usr_act;
      logic [31:0] rdata;
      logic        rvalid;
      logic        dma_irq;
      logic        user_irq;
      logic [3:0]  fetch_start;
      logic [3:0]  reset_request;
      logic [3:0]  user_reset;
   } top_state_type;
   top_state_type s_q, s_d;

   logic [15:0] base [4];
   logic [3:0]  sel;
   logic [31:0] ctl_w [4];
   logic [31:0] nxt_w [4];
   logic [31:0] own_w [4];
   logic [31:0] cnt_w [4];
   logic [3:0]  eng_irq;
   logic [3:0]  eng_fetch;
   logic [3:0]  eng_rreq;
   logic [3:0]  eng_rst;
   logic [7:0]  ofs;
   logic        raw_irq;
   logic        common_hit;

   assign base[0] = H2C_BASE_0;
   assign base[1] = H2C_BASE_1;
   assign base[2] = C2H_BASE_0;
   assign base[3] = C2H_BASE_1;
   assign ofs        = req.addr[7:0];
   assign common_hit = (req.addr == COMMON_BASE);

   ////////////////////////////////////////////////////////////////////////////////
   // One engine register set per channel; 0,1 host_to_card, 2,3 card_to_host
   for (genvar g = 0; g < 4; g++) begin : g_eng
      assign sel[g] = (req.addr[15:8] == base[g][15:8]);
      dma_engine_ctl u_ctl (
         .clk           (clk),
         .resetn        (resetn),
         .sel           (sel[g]),
         .wr            (req.wr),
         .ofs           (ofs),
         .wdata         (req.wdata),
         .ev            (events[g]),
         .user_ack      (user_ack[g]),
         .control_word  (ctl_w[g]),
         .next_ptr_word (nxt_w[g]),
         .host_ptr_word (own_w[g]),
         .irq           (eng_irq[g]),
         .fetch_start   (eng_fetch[g]),
         .reset_request (eng_rreq[g]),
         .engine_reset  (eng_rst[g])
      );
      dma_rate_counter #(.SAMPLE_LEN(SAMPLE_LEN)) u_rate (
         .clk        (clk),
         .resetn     (resetn),
         .bytes      (events[g].bytes),
         .count_word (cnt_w[g])
      );
   end

   assign raw_irq = |eng_irq;

   ////////////////////////////////////////////////////////////////////////////////
   // Common register, read mux and registered outputs
   always_comb begin
      s_d = s_q;
      s_d.rvalid = req.rd;
      s_d.rdata  = 32'h0;
      if (req.wr && common_hit) begin
         s_d.gie    = req.wdata[CMN_GIE];
         s_d.usr_en = req.wdata[CMN_USR_EN];
         if (req.wdata[CMN_USR_ACT]) s_d.usr_act = 1'b0;
      end
      if (user_irq_event && s_q.usr_en) s_d.usr_act = 1'b1;
      if (req.rd) begin
         if (common_hit) begin
            s_d.rdata[CMN_GIE]      = s_q.gie;
            s_d.rdata[CMN_IRQ_ACT]  = raw_irq & s_q.gie;
            s_d.rdata[CMN_IRQ_PEND] = raw_irq;
            s_d.rdata[CMN_IRQ_MODE] = LEGACY_IRQ;
            s_d.rdata[CMN_USR_EN]   = s_q.usr_en;
            s_d.rdata[CMN_USR_ACT]  = s_q.usr_act;
            s_d.rdata[CMN_H2C_LSB +: 2] = eng_irq[1:0];
            s_d.rdata[CMN_C2H_LSB +: 2] = eng_irq[3:2];
         end else begin
            for (int i = 0; i < 4; i++) begin
               if (sel[i]) begin
                  case (ofs)
                     OFS_CONTROL:    s_d.rdata = ctl_w[i];
                     OFS_NEXT_PTR:   s_d.rdata = nxt_w[i];
                     OFS_HOST_PTR:   s_d.rdata = own_w[i];
                     OFS_BYTE_COUNT: s_d.rdata = cnt_w[i];
                     default:        s_d.rdata = 32'h0;
                  endcase
               end
            end
         end
      end
      s_d.dma_irq       = raw_irq & s_q.gie;
      s_d.user_irq      = s_q.usr_act;
      s_d.fetch_start   = eng_fetch;
      s_d.reset_request = eng_rreq;
      s_d.user_reset    = eng_rst;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata         = s_q.rdata;
   assign rvalid        = s_q.rvalid;
   assign dma_irq       = s_q.dma_irq;
   assign user_irq      = s_q.user_irq;
   assign fetch_start   = s_q.fetch_start;
   assign reset_request = s_q.reset_request;
   assign user_reset    = s_q.user_reset;
endmodule // dma_regs_top
`default_nettype wire

// *** tb/dma_regs_top_assertions.sv ***
// Port-level checker for the DMA register block
`default_nettype none
module dma_regs_checker
   import dma_regs_pkg::*;
#(
   parameter logic LEGACY_IRQ = 1'b0
) (
   input wire logic        clk,
   input wire logic        resetn,
   input wire reg_req_type req,
   input wire logic [3:0]  user_ack,
   input wire logic [31:0] rdata,
   input wire logic        rvalid,
   input wire logic [3:0]  reset_request,
   input wire logic [3:0]  user_reset
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   //////////////////////////////////////////////////
   // Read answers: exactly one cycle after the strobe, never without one
   a_read_answer: assert property (req.rd |=> rvalid)
      else $error("read strobe not answered");
   a_no_stray: assert property (!req.rd |=> !rvalid)
      else $error("read answer without strobe");
   // Engine reset write on channel 0 gives one user reset pulse two cycles on
   a_user_reset: assert property (req.wr && req.addr == 16'h0004 && req.wdata[15]
      |-> ##2 user_reset[0] ##1 !user_reset[0]) else $error("user reset pulse wrong");
   // Reset request clears on acknowledge and only then (or on engine reset)
   // The request passes the engine flop and the output flop, hence two cycles
   a_ack_clears: assert property (user_ack[0] |-> ##2 !reset_request[0])
      else $error("acknowledge did not clear request");
   a_req_holds: assert property ($fell(reset_request[0]) |-> $past(user_ack[0], 2)
      || user_reset[0] || $past(user_reset[0])) else $error("request dropped early");
   // Common register: gated interrupt implies raw one; fixed fields
   a_gated_raw: assert property (rvalid && $past(req.rd) && $past(req.addr) == COMMON_BASE
      |-> !rdata[1] || rdata[2]) else $error("gated interrupt without raw");
   a_common_fixed: assert property (rvalid && $past(req.rd) && $past(req.addr) == COMMON_BASE
      |-> rdata[3] == LEGACY_IRQ && rdata[15:6] == 10'h000) else $error("common fixed bits");
   // Pointer low bits and unmapped space read zero
   a_ptr_align: assert property (rvalid && $past(req.rd) && ($past(req.addr[7:0]) == 8'h08
      || $past(req.addr[7:0]) == 8'h0c) |-> rdata[4:0] == 5'h00) else $error("pointer low bits");
   a_unmapped: assert property (rvalid && $past(req.rd) && $past(req.addr) == 16'h6000
      |-> rdata == 32'h0) else $error("unmapped read not zero");
endmodule // dma_regs_checker
bind dma_regs_top dma_regs_checker #(.LEGACY_IRQ(LEGACY_IRQ)) chk_u (.clk, .resetn, .req,
   .user_ack, .rdata, .rvalid, .reset_request, .user_reset);
`default_nettype wire

// *** tb/user_logic_model.sv ***
// Model of the user logic that answers engine reset requests
`default_nettype none
module user_logic_model (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic [3:0] reset_request,
   input  var  int         ack_delay,
   output var logic [3:0]  user_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   int wait_cnt [4];
   //////////////////////////////////////////////////
   // Acknowledge after ack_delay cycles; slow delays keep the request visible
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         user_ack <= '0;
         wait_cnt <= '{default: 0};
      end else begin
         for (int i = 0; i < 4; i++) begin
            user_ack[i] <= 1'b0;
            if (reset_request[i] && !user_ack[i]) begin
               wait_cnt[i] <= wait_cnt[i] + 1;
               if (wait_cnt[i] >= ack_delay) user_ack[i] <= 1'b1;
            end else wait_cnt[i] <= 0;
         end
      end
   end
endmodule // user_logic_model
`default_nettype wire

// *** tb/packet_dma_engine_regs_bench.sv ***
// Self-checking bench for the DMA register block
`default_nettype none
module packet_dma_engine_regs_bench
   import dma_regs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] B [4] = '{H2C_BASE_0, H2C_BASE_1, C2H_BASE_0, C2H_BASE_1};
   logic                clk, resetn, user_irq_event, rvalid, dma_irq, user_irq;
   reg_req_type         req;
   eng_event_type [3:0] events;
   eng_event_type       fl, fi;
   logic [3:0]          user_ack, fetch_start, reset_request, user_reset;
   logic [31:0]         rdata, v, w, sb;
   int                  ack_delay, err_total, check_count;
   //////////////////////////////////////////////////
   // Short sample interval keeps the byte counter test brief
   dma_regs_top #(.SAMPLE_LEN(100)) dut_u (.clk, .resetn, .req, .events, .user_ack,
      .user_irq_event, .rdata, .rvalid, .dma_irq, .user_irq, .fetch_start, .reset_request,
      .user_reset);
   user_logic_model model_u (.clk, .resetn, .reset_request, .ack_delay, .user_ack);
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   //////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Strobes last one cycle; the answer is read just after the taking edge
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge clk) req <= '{1'b1, 1'b0, a, d};
      @(posedge clk) req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, output logic [31:0] d);
      @(posedge clk) req <= '{1'b0, 1'b1, a, 32'h0};
      @(posedge clk) req.rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic rc(input logic [15:0] a, input logic [31:0] e);
      rd(a, v);
      chk(v, e);
   endtask
   task automatic pulse(input int i, input eng_event_type e);
      @(posedge clk) events[i] <= e;
      @(posedge clk) events[i] <= '0;
   endtask
   task automatic finish_test;
      if (err_total == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   //////////////////////////////////////////////////
   initial begin
      repeat (6000) @(posedge clk);
      err_total++;
      $display("MISMATCH %0t watchdog expired", $time);
      finish_test;
   end
   initial begin
      {req, events, user_irq_event, resetn, err_total, check_count} = '0;
      fl = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 16'h0};
      fi = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0};
      ack_delay = 2;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      rc(COMMON_BASE, 32'h0);
      rc(16'h6000, 32'h0);
      // Every event flag on every channel, then write-one-to-clear
      for (int i = 0; i < 4; i++) begin
         rc(B[i] + OFS_CONTROL, 32'h0);
         pulse(i, fl);
         rc(B[i] + OFS_CONTROL, 32'h3e);
         rd(COMMON_BASE, v);
         chk(v & 32'h7, 32'h0);
         wr(B[i] + OFS_CONTROL, 32'hffff_32fe);
         rc(B[i] + OFS_CONTROL, 32'h0);
      end
      // Engine interrupt through the global enable, one engine per direction
      for (int i = 0; i < 4; i += 2) begin
         sb = (i == 0) ? 32'h1_0000 : 32'h100_0000;
         wr(B[i] + OFS_CONTROL, 32'h1);
         pulse(i, fi);
         rc(COMMON_BASE, sb | 32'h4);
         chk(32'(dma_irq), 32'h0);
         wr(COMMON_BASE, 32'h1);
         rc(COMMON_BASE, sb | 32'h7);
         chk(32'(dma_irq), 32'h1);
         wr(B[i] + OFS_CONTROL, 32'h3);
         rc(COMMON_BASE, 32'h1);
         chk(32'(dma_irq), 32'h0);
         wr(COMMON_BASE, 32'h0);
      end
      // User interrupt enable and write-one-to-clear active bit
      wr(COMMON_BASE, 32'h10);
      @(posedge clk) user_irq_event <= 1'b1;
      @(posedge clk) user_irq_event <= 1'b0;
      rc(COMMON_BASE, 32'h30);
      chk(32'(user_irq), 32'h1);
      wr(COMMON_BASE, 32'h30);
      rc(COMMON_BASE, 32'h10);
      chk(32'(user_irq), 32'h0);
      // Pointers, start condition, starved and active status on channel 0
      wr(OFS_NEXT_PTR, 32'h1234_567f);
      wr(OFS_HOST_PTR, 32'h1234_567f);
      rc(OFS_HOST_PTR, 32'h1234_5660);
      wr(OFS_CONTROL, 32'h100);
      rc(OFS_CONTROL, 32'h900);
      chk(32'(fetch_start[0]), 32'h0);
      wr(OFS_HOST_PTR, 32'h1000);
      rc(OFS_CONTROL, 32'h100);
      chk(32'(fetch_start[0]), 32'h1);
      wr(OFS_NEXT_PTR, 32'h1000);
      rc(OFS_NEXT_PTR, 32'h1234_5660);
      @(posedge clk) events[0].active <= 1'b1;
      rc(OFS_CONTROL, 32'h500);
      @(posedge clk) events[0].active <= 1'b0;
      wr(OFS_CONTROL, 32'h8000);
      rc(OFS_CONTROL, 32'h0);
      chk(32'(fetch_start[0]), 32'h0);
      // Reset request with a prompt and a slow acknowledge
      for (int d = 2; d < 12; d += 6) begin
         ack_delay = d;
         wr(OFS_CONTROL, 32'h4000);
         rc(OFS_CONTROL, 32'h4000);
         // Look after the edge has settled, not in the time step that launches it
         for (int k = 0; k < 20 && reset_request[0] !== 1'b0; k++) begin
            @(posedge clk) #1;
         end
         rc(OFS_CONTROL, 32'h0);
      end
      // Byte counter: 80 bytes inside one sample interval read back as 20
      rd(C2H_BASE_0 + OFS_BYTE_COUNT, w);
      v = w; // Start equal so the loop waits for the next sample boundary
      for (int k = 0; k < 80 && v[1:0] == w[1:0]; k++) rd(C2H_BASE_0 + OFS_BYTE_COUNT, v);
      w = v;
      @(posedge clk) events[2].bytes <= 16'd8;
      repeat (10) @(posedge clk);
      events[2].bytes <= 16'h0;
      for (int k = 0; k < 80 && v[1:0] == w[1:0]; k++) rd(C2H_BASE_0 + OFS_BYTE_COUNT, v);
      chk(v, {30'd20, w[1:0] + 2'd1});
      finish_test;
   end
endmodule // packet_dma_engine_regs_bench
`default_nettype wire
